// ===== rtl/bst_bidir.sv
// One two-way pin with an output enable cell and a capture cell.
// Assumes core values for capture are already synchronised to the test clock.
`default_nettype none

module bst_bidir (
  // Core side
  input wire logic i_core_out,
  input wire logic i_core_oe,
  input wire logic i_core_out_s,
  input wire logic i_core_oe_s,
  // Pad side
  input wire logic i_pad_in_s,
  output logic o_pad_out,
  output logic o_pad_oe,
  // Test side
  input wire logic i_upd_out,
  input wire logic i_upd_oe,
  input wire logic i_ext,
  input wire logic i_hiz,
  output logic o_cap_out,
  output logic o_cap_oe
);

  // Control cell drives pin from update latches while i_ext is high, else from the core; high impedance wins
  assign o_pad_oe = i_hiz ? 1'b0 : (i_ext ? i_upd_oe : i_core_oe);
  assign o_pad_out = i_ext ? i_upd_out : i_core_out;

  // Observe cell sees core data while core drives and i_ext is low, else the pad
  assign o_cap_out = (i_core_oe_s && !i_ext) ? i_core_out_s : i_pad_in_s;
  assign o_cap_oe = i_core_oe_s;

endmodule

`default_nettype wire

// ===== rtl/bst_defs.svh
// Constants of the boundary-scan test port: opcodes, chain layout, reset values.
// Assumes it is included by its bare name from the test port design file.
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

`define BST_IR_W 6
`define BST_OP_EXTEST 6'h00
`define BST_OP_SAMPLE 6'h01
`define BST_OP_IDCODE 6'h02
`define BST_OP_HIGHZ 6'h03
`define BST_OP_CLAMP 6'h3E
`define BST_OP_BYPASS 6'h3F
`define BST_IR_CAPTURE 6'h2D
`define BST_IR_RESET `BST_OP_IDCODE

`define BST_ID_W 32
`define BST_N_LANE 6
`define BST_N_IO 16
`define BST_N_OBS 27
`define BST_N_SENSE 43
`define BST_N_DRIVE 38
`define BST_CHAIN_W 65
`define BST_POS_TX 27
`define BST_POS_IOE 33
`define BST_POS_IOD 49

`endif

// ===== rtl/bst_pkg.sv
// Types shared by the boundary-scan test port modules.
// Assumes bst_defs.svh is on the include path.
`default_nettype none

package bst_pkg;

  typedef enum logic [3:0] {
    BST_TLR,
    BST_RTI,
    BST_SEL_DR,
    BST_CAP_DR,
    BST_SHIFT_DR,
    BST_EXIT1_DR,
    BST_PAUSE_DR,
    BST_EXIT2_DR,
    BST_UPD_DR,
    BST_SEL_IR,
    BST_CAP_IR,
    BST_SHIFT_IR,
    BST_EXIT1_IR,
    BST_PAUSE_IR,
    BST_EXIT2_IR,
    BST_UPD_IR
  } bst_state_t;

  typedef enum logic [1:0] {
    BST_PATH_BYP,
    BST_PATH_BSR,
    BST_PATH_ID
  } bst_path_t;

  // Values the core wants on its driven pins; io order: master clk, master data,
  // slave clk, slave data, gpio 0..10, wake
  typedef struct packed {
    logic [5:0] lane_transmit_en;
    logic [15:0] io_out;
    logic [15:0] io_oe;
  } bst_drive_t;

  // Levels seen at the pins
  typedef struct packed {
    logic [5:0] lane_receive_neg;
    logic [5:0] lane_receive_pos;
    logic refclk_mode_in;
    logic [3:0] master_smbus_addr_pins;
    logic [3:0] slave_smbus_addr_pins;
    logic [5:0] sys_in;
    logic [15:0] io_in;
  } bst_sense_t;

endpackage

`default_nettype wire

// ===== rtl/bst_sync.sv
// Two-flop level synchroniser, one per bit of a vector.
// Assumes bits are independent levels; no word coherence is promised.
`default_nettype none

module bst_sync #(
  parameter int W = 1
) (
  // Clock and reset of the receiving domain
  input wire logic i_clk,
  input wire logic i_rst,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta <= '0;
      o_q <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q <= meta;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/bst_tap.sv
// Boundary-scan test access port: state machine, instruction register,
// bypass, identification and boundary chain over the DC-coupled pins.
// Assumes the tester drives i_tck, i_tms, i_tdi, i_trst_n; core runs on i_clk.
// Summary of operation
// - Sixteen-state controller and six-bit instruction register behind five test pins.
// - Active-low test reset clears the controller at once, no clock needed.
// - Mode select and serial input are taken only on rising test clock.
// - Serial output changes on falling test clock for sampling on next rise.
// - Serial output floats outside the two shift states.
// - Reset state reached by test reset or five rising edges with mode high.
// - Each rising edge moves to the state picked by the sampled mode value.
// - Serial input feeds the selected path: chain, instruction, identity or bypass.
// - An identification register can be scanned out to name the part.
// - Test logic follows the standard scan rules for DC-coupled pins.
// - No AC-coupled test mode; lanes get no time-varying test signalling.
// - Lane inputs and refclk mode observed; lane outputs controlled; bus pins both.
// - System inputs observed, wake pin both, switch mode and test pins none.
// - Observe cells capture; control cells drive an output or enable.
// - A shifted instruction takes effect only at Update-IR.
// - Code 111111 selects the one-bit bypass path.
// - Code 000011 floats every output and two-way pin.
`include "bst_defs.svh"
`default_nettype none

module bst_tap #(
  // Arbitrary identification value, low bit set as the standard asks
  parameter logic [31:0] P_IDCODE = 32'h0000_1001
) (
  // System clock domain
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Test port
  input wire logic i_tck,
  input wire logic i_trst_n,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  // Core side
  input wire bst_pkg::bst_drive_t i_core_drive,
  output bst_pkg::bst_sense_t o_core_sense,
  output logic o_core_test_mode,
  // Pads
  input wire bst_pkg::bst_sense_t i_pad_sense,
  output bst_pkg::bst_drive_t o_pad_drive
);

  bst_pkg::bst_state_t state;
  bst_pkg::bst_state_t next_state;
  bst_pkg::bst_path_t path;
  logic [`BST_IR_W-1:0] ir_shift;
  logic [`BST_IR_W-1:0] ir;
  logic [`BST_CHAIN_W-1:0] bsr_shift;
  logic [`BST_CHAIN_W-1:0] bsr_upd;
  logic [`BST_CHAIN_W-1:0] bsr_cap;
  logic [`BST_ID_W-1:0] id_shift;
  logic byp;
  logic ext_on;
  logic hiz_on;
  logic dr_out;
  bst_pkg::bst_sense_t sense_s;
  bst_pkg::bst_drive_t core_s;
  logic [`BST_N_IO-1:0] cap_io_out;
  logic [`BST_N_IO-1:0] cap_io_oe;
  logic [`BST_N_OBS-1:0] obs;

  always_comb
  begin
    next_state = state;
    unique case (state)
      bst_pkg::BST_TLR:
        next_state = i_tms ? bst_pkg::BST_TLR : bst_pkg::BST_RTI;
      bst_pkg::BST_RTI:
        next_state = i_tms ? bst_pkg::BST_SEL_DR : bst_pkg::BST_RTI;
      bst_pkg::BST_SEL_DR:
        next_state = i_tms ? bst_pkg::BST_SEL_IR : bst_pkg::BST_CAP_DR;
      bst_pkg::BST_CAP_DR:
        next_state = i_tms ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
      bst_pkg::BST_SHIFT_DR:
        next_state = i_tms ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
      bst_pkg::BST_EXIT1_DR:
        next_state = i_tms ? bst_pkg::BST_UPD_DR : bst_pkg::BST_PAUSE_DR;
      bst_pkg::BST_PAUSE_DR:
        next_state = i_tms ? bst_pkg::BST_EXIT2_DR : bst_pkg::BST_PAUSE_DR;
      bst_pkg::BST_EXIT2_DR:
        next_state = i_tms ? bst_pkg::BST_UPD_DR : bst_pkg::BST_SHIFT_DR;
      bst_pkg::BST_UPD_DR:
        next_state = i_tms ? bst_pkg::BST_SEL_DR : bst_pkg::BST_RTI;
      // Five highs reach reset from anywhere
      bst_pkg::BST_SEL_IR:
        next_state = i_tms ? bst_pkg::BST_TLR : bst_pkg::BST_CAP_IR;
      bst_pkg::BST_CAP_IR:
        next_state = i_tms ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
      bst_pkg::BST_SHIFT_IR:
        next_state = i_tms ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
      bst_pkg::BST_EXIT1_IR:
        next_state = i_tms ? bst_pkg::BST_UPD_IR : bst_pkg::BST_PAUSE_IR;
      bst_pkg::BST_PAUSE_IR:
        next_state = i_tms ? bst_pkg::BST_EXIT2_IR : bst_pkg::BST_PAUSE_IR;
      bst_pkg::BST_EXIT2_IR:
        next_state = i_tms ? bst_pkg::BST_UPD_IR : bst_pkg::BST_SHIFT_IR;
      bst_pkg::BST_UPD_IR:
        next_state = i_tms ? bst_pkg::BST_SEL_DR : bst_pkg::BST_RTI;
    endcase
  end

  // Test reset acts without a clock
  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      state <= bst_pkg::BST_TLR;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      ir_shift <= `BST_IR_RESET;
    end
    else if (state == bst_pkg::BST_CAP_IR)
    begin
      ir_shift <= `BST_IR_CAPTURE;
    end
    else if (state == bst_pkg::BST_SHIFT_IR)
    begin
      ir_shift <= {i_tdi, ir_shift[`BST_IR_W-1:1]};
    end
  end

  always_ff @(negedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      ir <= `BST_IR_RESET;
    end
    else if (state == bst_pkg::BST_TLR)
    begin
      ir <= `BST_IR_RESET;
    end
    else if (state == bst_pkg::BST_UPD_IR)
    begin
      ir <= ir_shift;
    end
  end

  // Instruction decode
  always_comb
  begin
    ext_on = 1'b0;
    hiz_on = 1'b0;
    path = bst_pkg::BST_PATH_BYP;
    unique case (ir)
      `BST_OP_EXTEST:
      begin
        ext_on = 1'b1;
        path = bst_pkg::BST_PATH_BSR;
      end
      `BST_OP_SAMPLE:
        path = bst_pkg::BST_PATH_BSR;
      `BST_OP_IDCODE:
        path = bst_pkg::BST_PATH_ID;
      `BST_OP_HIGHZ:
        hiz_on = 1'b1;
      `BST_OP_CLAMP:
        ext_on = 1'b1;
      default:
        path = bst_pkg::BST_PATH_BYP;
    endcase
  end

  // Pad levels into the test clock domain
  bst_sync #(
    .W(`BST_N_SENSE)
  ) u_sense_tck (
    .i_clk(i_tck),
    .i_rst(!i_trst_n),
    .i_d(i_pad_sense),
    .o_q(sense_s)
  );

  // Core drive values into the test clock domain, sampled bit by bit
  bst_sync #(
    .W(`BST_N_DRIVE)
  ) u_core_tck (
    .i_clk(i_tck),
    .i_rst(!i_trst_n),
    .i_d(i_core_drive),
    .o_q(core_s)
  );

  // System inputs observed; switch mode and test pins carry no cell
  // Lane receive, refclk mode and address pins observed
  assign obs = {
    sense_s.lane_receive_neg,
    sense_s.lane_receive_pos,
    sense_s.refclk_mode_in,
    sense_s.master_smbus_addr_pins,
    sense_s.slave_smbus_addr_pins,
    sense_s.sys_in
  };

  // Observe cells capture, control cells capture the core request
  assign bsr_cap = {cap_io_out, cap_io_oe, core_s.lane_transmit_en, obs};

  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      bsr_shift <= '0;
    end
    else if (path == bst_pkg::BST_PATH_BSR)
    begin
      if (state == bst_pkg::BST_CAP_DR)
      begin
        bsr_shift <= bsr_cap;
      end
      else if (state == bst_pkg::BST_SHIFT_DR)
      begin
        bsr_shift <= {i_tdi, bsr_shift[`BST_CHAIN_W-1:1]};
      end
    end
  end

  // Update latches on the falling edge so skew cannot corrupt them
  always_ff @(negedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      bsr_upd <= '0;
    end
    else if (state == bst_pkg::BST_UPD_DR && path == bst_pkg::BST_PATH_BSR)
    begin
      bsr_upd <= bsr_shift;
    end
  end

  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      id_shift <= P_IDCODE;
    end
    else if (path == bst_pkg::BST_PATH_ID)
    begin
      if (state == bst_pkg::BST_CAP_DR)
      begin
        id_shift <= P_IDCODE;
      end
      else if (state == bst_pkg::BST_SHIFT_DR)
      begin
        id_shift <= {i_tdi, id_shift[`BST_ID_W-1:1]};
      end
    end
  end

  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      byp <= 1'b0;
    end
    else if (path == bst_pkg::BST_PATH_BYP)
    begin
      if (state == bst_pkg::BST_CAP_DR)
      begin
        byp <= 1'b0;
      end
      else if (state == bst_pkg::BST_SHIFT_DR)
      begin
        byp <= i_tdi;
      end
    end
  end

  // Serial output of the selected data path
  always_comb
  begin
    unique case (path)
      bst_pkg::BST_PATH_BSR:
        dr_out = bsr_shift[0];
      bst_pkg::BST_PATH_ID:
        dr_out = id_shift[0];
      default:
        dr_out = byp;
    endcase
  end

  always_ff @(negedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end
    else
    begin
      o_tdo <= (state == bst_pkg::BST_SHIFT_IR) ? ir_shift[0] : dr_out;
      o_tdo_oe <= (state == bst_pkg::BST_SHIFT_IR) || (state == bst_pkg::BST_SHIFT_DR);
    end
  end

  // Lane control cell only gates the transmitter, never toggles it
  assign o_pad_drive.lane_transmit_en = hiz_on ? '0 :
    (ext_on ? bsr_upd[`BST_POS_TX +: `BST_N_LANE] : i_core_drive.lane_transmit_en);

  // Bus, gpio and wake pins with observe and control cells
  // DC-coupled two-way pins under full scan control
  for (genvar g = 0; g < `BST_N_IO; g++)
  begin : g_io
    bst_bidir u_io (
      .i_core_out(i_core_drive.io_out[g]),
      .i_core_oe(i_core_drive.io_oe[g]),
      .i_core_out_s(core_s.io_out[g]),
      .i_core_oe_s(core_s.io_oe[g]),
      .i_pad_in_s(sense_s.io_in[g]),
      .o_pad_out(o_pad_drive.io_out[g]),
      .o_pad_oe(o_pad_drive.io_oe[g]),
      .i_upd_out(bsr_upd[`BST_POS_IOD + g]),
      .i_upd_oe(bsr_upd[`BST_POS_IOE + g]),
      .i_ext(ext_on),
      .i_hiz(hiz_on),
      .o_cap_out(cap_io_out[g]),
      .o_cap_oe(cap_io_oe[g])
    );
  end

  // Pad levels to the core on its own clock
  bst_sync #(
    .W(`BST_N_SENSE)
  ) u_sense_core (
    .i_clk(i_clk),
    .i_rst(i_sys_rst),
    .i_d(i_pad_sense),
    .o_q(o_core_sense)
  );

  // Core learns that test logic owns the pins; a level, so two flops suffice
  bst_sync u_mode_core (
    .i_clk(i_clk),
    .i_rst(i_sys_rst),
    .i_d(ext_on || hiz_on),
    .o_q(o_core_test_mode)
  );

endmodule

`default_nettype wire

// ===== verif/bst_tap_assertions.sv
// Checker for the test port: reference controller plus pin-level properties.
// Assumes it is bound to bst_tap and sees only that module's ports.
`default_nettype none

module bst_chk #(
  parameter logic [31:0] P_IDCODE = 32'h0000_1001
) (
  // Clocks and resets
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_tck,
  input wire logic i_trst_n,
  // Test port
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic o_tdo,
  input wire logic o_tdo_oe,
  // Pins
  input wire bst_pkg::bst_drive_t i_core_drive,
  input wire bst_pkg::bst_drive_t o_pad_drive
);
  // Next-state tables by tms, states numbered as the package enum
  localparam logic [63:0] NX0 = 64'h1BDDBBA146644311;
  localparam logic [63:0] NX1 = 64'h2FEFCC0287855920;
  logic [3:0] st;
  logic [5:0] ir_sh;
  logic [5:0] ir;
  logic [2:0] ones;
  logic tdo_r;

  always_ff @(posedge i_tck or negedge i_trst_n)
    if (!i_trst_n)
      st <= 4'h0;
    else
      st <= i_tms ? NX1[{st, 2'h0} +: 4] : NX0[{st, 2'h0} +: 4];

  always_ff @(posedge i_tck or negedge i_trst_n)
    if (!i_trst_n)
      ir_sh <= 6'h00;
    else if (st == 4'hA)
      ir_sh <= 6'h2D;
    else if (st == 4'hB)
      ir_sh <= {i_tdi, ir_sh[5:1]};

  always_ff @(negedge i_tck or negedge i_trst_n)
    if (!i_trst_n)
      ir <= 6'h02;
    else if (st == 4'h0)
      ir <= 6'h02;
    else if (st == 4'hF)
      ir <= ir_sh;

  // Saturates so a long run of ones cannot wrap back below five
  always_ff @(posedge i_tck or negedge i_trst_n)
    if (!i_trst_n)
      ones <= 3'h0;
    else
      ones <= !i_tms ? 3'h0 : (ones == 3'h7 ? ones : ones + 3'h1);

  always_ff @(posedge i_tck or negedge i_trst_n)
    if (!i_trst_n)
      tdo_r <= 1'h0;
    else
      tdo_r <= o_tdo;

  chk_tdo_oe_shift: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    o_tdo_oe == (st == 4'h4 || st == 4'hB)) else $error("tdo enable wrong");
  chk_tdo_fall_only: assert property (@(negedge i_tck) disable iff (!i_trst_n)
    o_tdo == tdo_r) else $error("tdo moved in high phase");
  chk_trst_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_trst_n |-> !o_tdo_oe && !o_tdo) else $error("tdo active in reset");
  chk_ir_capture: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    st == 4'hB && $past(st) == 4'hA |-> o_tdo) else $error("ir capture bit");
  chk_bypass_bit: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    st == 4'h4 && $past(st) == 4'h3 && ir > 6'h02 |-> !o_tdo) else $error("bypass bit");
  chk_highz_pads: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ir == 6'h03 |-> o_pad_drive.io_oe == 16'h0 && o_pad_drive.lane_transmit_en == 6'h0)
    else $error("highz pads driven");
  chk_core_pads: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !(ir inside {6'h00, 6'h03, 6'h3E}) |-> o_pad_drive == i_core_drive)
    else $error("pads not from core");
  chk_five_ones: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    ones >= 3'h5 |-> !o_tdo_oe && o_pad_drive == i_core_drive) else $error("tms reset");
endmodule

bind bst_tap bst_chk #(.P_IDCODE(P_IDCODE)) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tck(i_tck), .i_trst_n(i_trst_n),
  .i_tms(i_tms), .i_tdi(i_tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
  .i_core_drive(i_core_drive), .o_pad_drive(o_pad_drive)
);

`default_nettype wire

// ===== verif/bst_tester.sv
// Tester model: drives the test port one test clock at a time.
// Assumes calls come from one process; the test clock stands still between them.
`default_nettype none

module bst_tester (
  // Test port outputs
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n,
  // Answer from the device
  input wire logic i_tdo,
  input wire logic i_tdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    o_tck = 1'h0;
    o_tms = 1'h1;
    o_tdi = 1'h1;
    o_trst_n = 1'h0;
  end

  // tms and tdi set in the low phase, held across the rise
  task automatic tick(input logic tms, input logic tdi, output logic [1:0] res);
    o_tms = tms;
    o_tdi = tdi;
    #7.5;
    // A floating output reads inverted, so a stray sample cannot pass
    res = {i_tdo_oe, i_tdo_oe ? i_tdo : !i_tdo};
    o_tck = 1'h1;
    #7.5;
    o_tck = 1'h0;
  endtask

  // reset pulse with no clock edges
  task automatic reset_pulse();
    o_trst_n = 1'h0;
    #20;
    o_trst_n = 1'h1;
  endtask

  // one scan from Run-Test/Idle back to it, first bit out first
  task automatic scan(input logic ir, input int n, input logic [99:0] din,
                      output logic [99:0] dout, output logic [99:0] oe);
    logic [1:0] r;
    dout = '0;
    oe = '0;
    tick(1'h1, 1'h1, r);
    if (ir)
      tick(1'h1, 1'h1, r);
    tick(1'h0, 1'h1, r);
    tick(1'h0, 1'h1, r);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], r);
      {oe[i], dout[i]} = r;
    end
    tick(1'h1, 1'h1, r);
    tick(1'h0, 1'h1, r);
  endtask
endmodule

`default_nettype wire

// ===== verif/testbench.sv
// Testbench for the test port: instruction table, chain preload, both resets.
// Assumes bst_tap, its checker and the tester model are compiled before it.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // Arbitrary identification value, low bit set
  localparam logic [31:0] ID = 32'h1234_5679;
  typedef struct packed {logic [5:0] op; logic tm; logic [6:0] len;} bst_row_t;
  logic i_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  wire tck, trst_n, tms, tdi, tdo, tdo_oe;
  bst_pkg::bst_drive_t core, pdrv;
  bst_pkg::bst_sense_t pad, sense;
  logic tm;
  logic [1:0] r;
  logic [99:0] dout, oe, v;
  int bad_count = 0;
  int cmp_count = 0;
  bst_row_t rows[9];

`define CHK(n, e, s) \
  begin \
    cmp_count++; \
    if ((s) !== (e)) \
    begin \
      bad_count++; \
      $display("[ERR] %s exp %0h got %0h", n, e, s); \
    end \
  end

  always #2 i_clk = ~i_clk;

  bst_tap #(.P_IDCODE(ID)) uut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tck(tck), .i_trst_n(trst_n),
    .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .i_core_drive(core), .o_core_sense(sense), .o_core_test_mode(tm),
    .i_pad_sense(pad), .o_pad_drive(pdrv)
  );

  bst_tester tester (
    .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n),
    .i_tdo(tdo), .i_tdo_oe(tdo_oe)
  );

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic ir_load(input logic [5:0] op);
    tester.scan(1'h1, 6, {94'h0, op}, dout, oe);
    `CHK("ir_capture", 6'h2D, dout[5:0])
  endtask

  task automatic dr(input int n, input logic [99:0] d);
    tester.scan(1'h0, n, d, dout, oe);
    `CHK("shift_oe", {100{1'h1}} >> (100 - n), oe)
  endtask

  // Bounded run: a hang is reported as a mismatch
  initial
  begin
    #100000;
    bad_count++;
    finish_test();
  end

  initial
  begin
    core = {6'h2A, 16'hA5C3, 16'h00FF};
    pad = {6'h15, 6'h2A, 1'h1, 4'h9, 4'h6, 6'h33, 16'h3C5A};
    rows = '{'{6'h00, 1'h1, 7'h41}, '{6'h01, 1'h0, 7'h41}, '{6'h02, 1'h0, 7'h20},
             '{6'h03, 1'h1, 7'h01}, '{6'h04, 1'h0, 7'h01}, '{6'h2D, 1'h0, 7'h01},
             '{6'h3D, 1'h0, 7'h01}, '{6'h3E, 1'h1, 7'h01}, '{6'h3F, 1'h0, 7'h01}};
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    `CHK("sense_rst", 43'h0, sense)
    i_sys_rst = 1'h0;
    tester.reset_pulse();
    tester.tick(1'h0, 1'h1, r);
    foreach (rows[k])
    begin
      ir_load(rows[k].op);
      repeat (3) @(negedge i_clk);
      `CHK("test_mode", rows[k].tm, tm)
      if (!rows[k].tm) `CHK("pads_core", core, pdrv)
      if (rows[k].op == 6'h03) `CHK("pads_hiz", 22'h0, {pdrv.lane_transmit_en, pdrv.io_oe})
      dr(100, 100'h1);
      `CHK("path", 100'h1 << rows[k].len, dout & ~((100'h1 << rows[k].len) - 100'h1))
      if (rows[k].len == 7'h01) `CHK("bypass_cap", 1'h0, dout[0])
      if (rows[k].len == 7'h20) `CHK("idcode", ID, dout[31:0])
    end
    // Preload, then drive the pins from the latches
    v = {35'h0, 65'h1_2345_6789_ABCD_EF01};
    ir_load(6'h01);
    dr(65, v);
    `CHK("observe", pad[42:16], dout[26:0])
    `CHK("io_cap", (core.io_out & core.io_oe) | (pad.io_in & ~core.io_oe), dout[64:49])
    `CHK("ctl_cap", {core.io_oe, core.lane_transmit_en}, dout[48:27])
    ir_load(6'h00);
    `CHK("extest_pads", {v[32:27], v[64:49], v[48:33]}, pdrv)
    dr(65, v);
    `CHK("extest_cap", pad.io_in, dout[64:49])
    // Core-side reset in mid-run clears only the core synchronisers
    @(negedge i_clk);
    i_sys_rst = 1'h1;
    @(negedge i_clk);
    `CHK("sys_rst_mode", 1'h0, tm)
    `CHK("sys_rst_sense", 43'h0, sense)
    i_sys_rst = 1'h0;
    repeat (3) @(negedge i_clk);
    `CHK("sys_rel_mode", 1'h1, tm)
    `CHK("core_sense", pad, sense)
    // Test reset in mid-shift, no clock
    tester.tick(1'h1, 1'h1, r);
    tester.tick(1'h0, 1'h1, r);
    tester.tick(1'h0, 1'h1, r);
    tester.tick(1'h0, 1'h1, r);
    `CHK("oe_shift", 1'h1, r[1])
    fork
      tester.reset_pulse();
      begin
        #5;
        `CHK("trst_oe", 1'h0, tdo_oe)
      end
    join
    `CHK("trst_pads", core, pdrv)
    tester.tick(1'h0, 1'h1, r);
    dr(32, 100'h0);
    `CHK("trst_ir", ID, dout[31:0])
    // Five ones from Shift-DR return to reset
    ir_load(6'h3F);
    tester.tick(1'h1, 1'h1, r);
    tester.tick(1'h0, 1'h1, r);
    tester.tick(1'h0, 1'h1, r);
    repeat (5) tester.tick(1'h1, 1'h1, r);
    tester.tick(1'h0, 1'h1, r);
    dr(32, 100'h0);
    `CHK("tms_reset_ir", ID, dout[31:0])
    finish_test();
  end
endmodule

`default_nettype wire
